// ==== bpf_pkg.sv ====
package bpf_pkg;

    // ---------------------------------------------------------------
    // frame and word constants
    // ---------------------------------------------------------------
    localparam logic [23:0] SYNC_WORD = 24'hfaf320;
    localparam logic [15:0] FILL_INFO = 16'haaaa;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [3:0] CID_OVERFLOW = 4'h0;
    localparam logic [3:0] CID_ERR_A = 4'hc;
    localparam logic [3:0] CID_ERR_B = 4'h8;
    localparam logic [4:0] BIT_LAST = 5'h17;
    localparam logic [8:0] TIME_SLOTS = 9'h003;
    localparam logic [8:0] FLEN_MIN = 9'h080;
    localparam logic [8:0] FLEN_MAX = 9'h1ff;

    // ---------------------------------------------------------------
    // capture buffer
    // ---------------------------------------------------------------
    localparam int FIFO_AW = 4;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;

    // ---------------------------------------------------------------
    // register map, byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FLEN = 8'h04;
    localparam logic [7:0] OFF_BDIV = 8'h08;
    localparam logic [7:0] OFF_LBL = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_DROP = 8'h14;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [8:0] FLEN_RESET = 9'h080;
    localparam logic [15:0] BDIV_RESET = 16'h0000;
    localparam logic [15:0] LBL_RESET = 16'h7650;

    // control fields, bit 0 is enable
    typedef struct packed {
        logic nofill; // bit 4: suppress fill words
        logic crc;    // bit 3: crc word closes frame
        logic tim;    // bit 2: frame time words
        logic par;    // bit 1: odd parity in bit 1
        logic en;     // bit 0: formatter running
    } bpf_ctrl_t;

    // label register fields
    typedef struct packed {
        logic [3:0] time_cid; // bits 15:12
        logic [3:0] fill_cid; // bits 11:8
        logic [3:0] crc_cid;  // bits 7:4
        logic [3:0] sys_bus;  // bits 3:0
    } bpf_lbl_t;

    // one captured bus word
    typedef struct packed {
        logic [3:0] bus;
        logic [3:0] cid;
        logic [15:0] info;
        logic err;
        logic on_b;
    } bpf_cap_t;

    // frame time sampled at frame start
    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
        logic [15:0] us;
    } bpf_time_t;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // label, content label, information field; bit 1 is msb
    function automatic logic [23:0] fmt_word(input logic par,
        input logic [3:0] bus, input logic [3:0] cid,
        input logic [15:0] info);
        logic [22:0] rest;
        rest = {bus[2:0], cid, info};
        if (par) begin
            fmt_word = {~(^rest), rest};
        end else begin
            fmt_word = {bus, cid, info};
        end
    endfunction

    // sixteen info bits, most significant first
    function automatic logic [15:0] crc16(input logic [15:0] c,
        input logic [15:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            fb = r[15] ^ d[i];
            r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        crc16 = r;
    endfunction

endpackage

// ==== bpf_formatter.sv ====
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
module bpf_formatter (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // capture side
    input wire logic IN_VALID,
    input wire bpf_pkg::bpf_cap_t IN_WORD,
    output logic IN_READY,
    input wire bpf_pkg::bpf_time_t FRAME_TIME,
    // serial pcm output
    output logic PCM_DATA,
    output logic PCM_BIT,
    output logic PCM_FRAME
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        bpf_pkg::bpf_ctrl_t ctrl;     // control register
        logic [8:0] flen;             // words per frame
        logic [15:0] bdiv;            // clocks per bit minus one
        bpf_pkg::bpf_lbl_t lbl;       // label register
        logic [31:0] prdata;          // read data latched at setup
        logic [15:0][23:0] mem;       // capture buffer words
        logic [3:0] wptr;             // buffer write pointer
        logic [3:0] rptr;             // buffer read pointer
        logic [4:0] cnt;              // buffer fill level
        logic ovf;                    // overflow pending
        logic [3:0] ovf_bus;          // bus of first dropped word
        logic [15:0] drops;           // dropped word counter
        logic [23:0] shift;           // serial shift register
        logic [4:0] bitn;             // bit index in word
        logic busy;                   // shift register holds a word
        logic sof;                    // current word is sync
        logic [15:0] div;             // bit rate divider
        logic [8:0] slot;             // next word slot in frame
        logic [15:0] crc;             // running check sequence
        bpf_pkg::bpf_time_t tm;       // time latched at frame start
        logic pdata;                  // serial data out
        logic pbit;                   // bit strobe out
        logic pframe;                 // first bit of frame
    } bpf_state_t;

    bpf_state_t st;
    bpf_state_t next_st;

    // ---------------------------------------------------------------
    // combinational next state
    // ---------------------------------------------------------------
    logic apb_setup;     // first phase of a transfer
    logic apb_wr;        // write taking effect
    logic hit;           // address is mapped
    logic [31:0] rmux;   // read data for current address
    logic push;          // word enters buffer
    logic pop;           // word leaves buffer
    logic [23:0] pword;  // word being pushed
    logic full;          // buffer has no room
    logic tick;          // bit time boundary
    logic last;          // next slot is last of frame
    logic load;          // new word enters shift register
    logic [23:0] lword;  // word being loaded
    logic [3:0] dcid;    // content label of captured word
    logic [8:0] wlen;    // clamped frame length write

    // status view of the block's own state
    always_comb begin
        hit = 1'b1;
        rmux = 32'h00000000;
        case (PADDR)
            bpf_pkg::OFF_CTRL: begin
                rmux = {27'h0000000, st.ctrl};
            end
            bpf_pkg::OFF_FLEN: begin
                rmux = {23'h000000, st.flen};
            end
            bpf_pkg::OFF_BDIV: begin
                rmux = {16'h0000, st.bdiv};
            end
            bpf_pkg::OFF_LBL: begin
                rmux = {16'h0000, st.lbl};
            end
            bpf_pkg::OFF_STAT: begin
                rmux = {16'h0000, st.slot, st.cnt, st.busy, st.ovf};
            end
            bpf_pkg::OFF_DROP: begin
                rmux = {16'h0000, st.drops};
            end
            default: begin
                hit = 1'b0; // unmapped: error, reads zero
            end
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.pbit = 1'b0;
        next_st.pframe = 1'b0;
        apb_setup = PSEL & ~PENABLE;
        apb_wr = PSEL & PENABLE & PWRITE & hit;
        push = 1'b0;
        pop = 1'b0;
        pword = 24'h000000;
        load = 1'b0;
        lword = 24'h000000;
        full = (st.cnt == bpf_pkg::FIFO_DEPTH);
        last = (st.slot == st.flen - 9'h001);
        wlen = PWDATA[8:0];

        // register access; read data settles during setup
        if (apb_setup) begin
            next_st.prdata = rmux;
        end
        // out of range lengths are clamped into the legal window
        if (PWDATA[8:0] < bpf_pkg::FLEN_MIN) begin
            wlen = bpf_pkg::FLEN_MIN;
        end
        if (apb_wr) begin
            case (PADDR)
                bpf_pkg::OFF_CTRL: begin
                    next_st.ctrl = PWDATA[4:0];
                end
                bpf_pkg::OFF_FLEN: begin
                    next_st.flen = wlen;
                end
                bpf_pkg::OFF_BDIV: begin
                    next_st.bdiv = PWDATA[15:0];
                end
                bpf_pkg::OFF_LBL: begin
                    next_st.lbl = PWDATA[15:0];
                end
                default: begin
                    next_st.ctrl = st.ctrl; // read-only or unmapped
                end
            endcase
        end

        // errored captures override the supplied content label
        dcid = IN_WORD.cid;
        if (IN_WORD.err) begin
            dcid = IN_WORD.on_b ? bpf_pkg::CID_ERR_B
                                : bpf_pkg::CID_ERR_A;
        end

        // capture side: marker first, then data
        if (st.ovf) begin
            if (!full) begin
                push = 1'b1;
                pword = bpf_pkg::fmt_word(st.ctrl.par, st.ovf_bus,
                    bpf_pkg::CID_OVERFLOW, st.drops);
                next_st.ovf = 1'b0;
            end
            if (IN_VALID) begin
                next_st.drops = st.drops + 16'h0001;
            end
        end else if (IN_VALID) begin
            if (full) begin
                next_st.ovf = 1'b1;
                next_st.ovf_bus = IN_WORD.bus;
                next_st.drops = st.drops + 16'h0001;
            end else begin
                push = 1'b1;
                pword = bpf_pkg::fmt_word(st.ctrl.par, IN_WORD.bus,
                    dcid, IN_WORD.info);
            end
        end

        // fixed bit clock; the divider never pauses
        tick = (st.div == 16'h0000);
        if (tick) begin
            next_st.div = st.bdiv;
        end else begin
            next_st.div = st.div - 16'h0001;
        end
        if (tick && st.busy) begin
            next_st.pdata = st.shift[23];
            next_st.pbit = 1'b1;
            next_st.pframe = st.sof && (st.bitn == 5'h00);
            next_st.shift = {st.shift[22:0], 1'b0};
            if (st.bitn == bpf_pkg::BIT_LAST) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.bitn = st.bitn + 5'h01;
            end
        end

        // word selection by frame position
        if (!next_st.busy && st.ctrl.en) begin
            if (st.slot == 9'h000) begin
                load = 1'b1;
                lword = bpf_pkg::SYNC_WORD;
                next_st.tm = FRAME_TIME;
                next_st.crc = bpf_pkg::crc16(bpf_pkg::CRC_INIT,
                    lword[15:0]);
            end else if (st.ctrl.tim && st.slot <= bpf_pkg::TIME_SLOTS) begin
                load = 1'b1;
                case (st.slot[1:0])
                    2'h1: lword = bpf_pkg::fmt_word(st.ctrl.par,
                        st.lbl.sys_bus, st.lbl.time_cid, st.tm.hi);
                    2'h2: lword = bpf_pkg::fmt_word(st.ctrl.par,
                        st.lbl.sys_bus, st.lbl.time_cid, st.tm.lo);
                    default: lword = bpf_pkg::fmt_word(st.ctrl.par,
                        st.lbl.sys_bus, st.lbl.time_cid, st.tm.us);
                endcase
                next_st.crc = bpf_pkg::crc16(st.crc, lword[15:0]);
            end else if (st.ctrl.crc && last) begin
                load = 1'b1;
                // crc word itself never feeds the sequence
                lword = bpf_pkg::fmt_word(st.ctrl.par, st.lbl.sys_bus,
                    st.lbl.crc_cid, st.crc);
            end else if (st.cnt != 5'h00) begin
                load = 1'b1;
                pop = 1'b1;
                lword = st.mem[st.rptr];
                next_st.crc = bpf_pkg::crc16(st.crc, lword[15:0]);
            end else if (!st.ctrl.nofill) begin
                load = 1'b1;
                lword = bpf_pkg::fmt_word(st.ctrl.par, st.lbl.sys_bus,
                    st.lbl.fill_cid, bpf_pkg::FILL_INFO);
                next_st.crc = bpf_pkg::crc16(st.crc, lword[15:0]);
            end
            // with fill suppressed the line simply waits for data
        end
        if (!next_st.busy && !st.ctrl.en) begin
            next_st.slot = 9'h000; // restart at sync once enabled
        end
        if (load) begin
            next_st.shift = lword;
            next_st.busy = 1'b1;
            next_st.bitn = 5'h00;
            next_st.sof = (st.slot == 9'h000);
            next_st.slot = last ? 9'h000 : st.slot + 9'h001;
        end

        // buffer pointers, arrival order preserved
        if (push) begin
            next_st.mem[st.wptr] = pword;
            next_st.wptr = st.wptr + 4'h1;
        end
        if (pop) begin
            next_st.rptr = st.rptr + 4'h1;
        end
        next_st.cnt = st.cnt + {4'h0, push} - {4'h0, pop};
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st <= '0;
            st.ctrl <= bpf_pkg::CTRL_RESET;
            st.flen <= bpf_pkg::FLEN_RESET;
            st.bdiv <= bpf_pkg::BDIV_RESET;
            st.lbl <= bpf_pkg::LBL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // ready is advisory: the buffer drops rather than stalls
    assign IN_READY = ~st.ovf & (st.cnt != bpf_pkg::FIFO_DEPTH);
    assign PRDATA = st.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit;
    assign PCM_DATA = st.pdata;
    assign PCM_BIT = st.pbit;
    assign PCM_FRAME = st.pframe;

endmodule

// ==== bpf_formatter_props.sv ====
`timescale 1ns/100ps
module bpf_formatter_props (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // serial output
    input wire logic PCM_DATA,
    input wire logic PCM_BIT,
    input wire logic PCM_FRAME
);
    // ----
    // mirrors of the settings and of the stream
    // ----
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    logic [4:0] ctrl; // control bits as written
    logic [8:0] flen; // frame length as clamped
    logic [15:0] bdiv, gap; // bit divider, cycles since a bit
    logic [4:0] pos; // bit place in word
    logic [8:0] widx; // words done in frame
    logic [22:0] sh; // earlier bits of the word
    logic seen; // a whole frame may end here
    logic wr;
    logic [23:0] word;
    assign wr = PSEL && PENABLE && PWRITE && PREADY;
    assign word = {sh, PCM_DATA};
    // a control write restarts the frame, so the length check waits
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl <= '0;
            flen <= 9'h080;
            bdiv <= '0;
            gap <= '0;
            pos <= '0;
            widx <= '0;
            sh <= '0;
            seen <= 1'b0;
        end else begin
            gap <= PCM_BIT ? 16'h0000 : gap + 16'h0001;
            if (PCM_BIT) begin
                sh <= word[22:0];
                pos <= (pos == 5'h17) ? 5'h00 : pos + 5'h01;
                widx <= PCM_FRAME ? 9'h000 : widx + (pos == 5'h17);
                seen <= seen | PCM_FRAME;
            end
            if (wr && PADDR == bpf_pkg::OFF_CTRL) begin
                ctrl <= PWDATA[4:0];
                seen <= 1'b0;
            end
            if (wr && PADDR == bpf_pkg::OFF_FLEN) begin
                flen <= (PWDATA[8:0] < 9'h080) ? 9'h080 : PWDATA[8:0];
            end
            if (wr && PADDR == bpf_pkg::OFF_BDIV) begin
                bdiv <= PWDATA[15:0];
            end
        end
    end
    // ----
    // checks
    // ----
    ready_now_a: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access phase without ready");
    unmapped_err_a: assert property (PSEL && PENABLE && PADDR[1:0] == 2'h0
        |-> PSLVERR == (PADDR > bpf_pkg::OFF_DROP))
        else $error("error flag wrong for address");
    bit_rate_a: assert property (
        PCM_BIT && pos != 5'h00 |-> gap == bdiv)
        else $error("bit spacing differs from divider");
    bit_pulse_a: assert property (PCM_BIT && bdiv != 16'h0000 |=> !PCM_BIT)
        else $error("bit strobe longer than one cycle");
    frame_start_a: assert property (
        PCM_FRAME |-> PCM_BIT && PCM_DATA && pos == 5'h00)
        else $error("frame mark not on leading sync bit");
    sync_word_a: assert property (
        PCM_BIT && pos == 5'h17 && widx == 9'h000 |-> word == 24'hfaf320)
        else $error("first word of frame not sync");
    frame_len_a: assert property (
        PCM_FRAME && PCM_BIT && seen |-> widx == flen)
        else $error("frame length differs from setting");
    odd_parity_a: assert property (
        PCM_BIT && pos == 5'h17 && widx != 9'h000 && ctrl[1] |-> ^word)
        else $error("word parity not odd");
    time_label_a: assert property (
        PCM_BIT && pos == 5'h17 && ctrl[2] && widx > 9'h000
        && widx < 9'h004 |-> word[19:16] == 4'h7)
        else $error("time slot carries wrong label");
    crc_label_a: assert property (
        PCM_BIT && pos == 5'h17 && ctrl[3] && widx == flen - 9'h001
        |-> word[19:16] == 4'h5)
        else $error("last slot label not crc");
endmodule
bind bpf_formatter bpf_formatter_props u_props (.CORE_CLK(CORE_CLK),
    .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PCM_DATA(PCM_DATA), .PCM_BIT(PCM_BIT), .PCM_FRAME(PCM_FRAME));

// ==== bpf_pcm_rx.sv ====
`timescale 1ns/100ps
module bpf_pcm_rx (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial stream
    input wire logic pcm_data,
    input wire logic pcm_bit,
    input wire logic pcm_frame
);
    // ----
    // word assembly, a recorder input that only listens
    // ----
    logic [23:0] mem [0:511]; // last word per slot
    logic [23:0] sh; // word in flight
    int nb, slot, frames, gap; // bits, slot, syncs, idle cycles
    // sync mark restarts the slot count; whole words only
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sh = '0;
            nb = 0;
            slot = 0;
            frames = 0;
            gap = 0;
        end else begin
            gap = pcm_bit ? 0 : gap + 1;
            if (pcm_bit && pcm_frame) begin
                nb = 0;
                slot = 0;
                frames++;
            end
            if (pcm_bit) begin
                sh = {sh[22:0], pcm_data};
                nb++;
            end
            if (nb == 24) begin
                mem[slot[8:0]] = sh;
                slot++;
                nb = 0;
            end
        end
    end
endmodule

// ==== bpf_formatter_test.sv ====
`timescale 1ns/100ps
module bpf_formatter_test;
    // ----
    // stimulus and results
    // ----
    logic clk, nrst, psel, penable, pwrite, in_valid, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, q, prdata;
    logic pready, pslverr, in_ready, pcm_data, pcm_bit, pcm_frame;
    bpf_pkg::bpf_cap_t in_word;
    bpf_pkg::bpf_time_t ftime;
    logic [23:0] ew [0:511]; // expected word per slot
    logic [15:0] crc;
    int fails, checks_done, f0;
    bpf_formatter dut (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IN_VALID(in_valid), .IN_WORD(in_word),
        .IN_READY(in_ready), .FRAME_TIME(ftime), .PCM_DATA(pcm_data),
        .PCM_BIT(pcm_bit), .PCM_FRAME(pcm_frame));
    bpf_pcm_rx rx (.clk(clk), .nrst(nrst), .pcm_data(pcm_data),
        .pcm_bit(pcm_bit), .pcm_frame(pcm_frame));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----
    // helpers
    // ----
    function automatic logic [23:0] fmtw(input logic p,
        input logic [3:0] b, input logic [3:0] c, input logic [15:0] d);
        logic [22:0] r;
        r = {b[2:0], c, d};
        fmtw = p ? {~^r, r} : {b, c, d};
    endfunction
    function automatic logic [15:0] idat(input int i);
        idat = {i[7:0], 8'h3c};
    endfunction
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task print_verdict;
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one apb transfer; request held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", q, e);
    endtask
    // words 2 and 3 carry bus errors on the two buses
    task automatic push(input logic [3:0] b, input int i);
        @(posedge clk);
        in_valid <= 1'b1;
        in_word <= {b, 4'h9, idat(i), i == 2 || i == 3, i == 3};
    endtask
    task automatic fill(input int a, input int b, input logic p);
        for (int i = a; i < b; i++) begin
            ew[i] = fmtw(p, 4'h0, 4'h6, 16'haaaa);
        end
    endtask
    // check sequence over every info field but the last slot
    task automatic seal(input int n, input logic p);
        crc = 16'h0000;
        for (int i = 0; i < n - 1; i++) begin
            for (int k = 15; k >= 0; k--) begin
                crc = {crc[14:0], 1'b0} ^ ({16{crc[15] ^ ew[i][k]}}
                    & 16'h8005);
            end
        end
        ew[n - 1] = fmtw(p, 4'h0, 4'h5, crc);
    endtask
    // waits for the second sync after f0, then compares the frame just ended
    task automatic frame(input int n);
        int t;
        t = 0;
        while (rx.frames < f0 + 2 && t < 20000) begin
            @(negedge clk);
            t++;
        end
        for (int i = 0; i < n; i++) begin
            chk("word", {8'h0, rx.mem[i]}, {8'h0, ew[i]});
        end
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        print_verdict();
    end
    // ----
    // main sequence
    // ----
    initial begin
        {nrst, psel, penable, pwrite, in_valid, paddr, pwdata} = '0;
        in_word = '0;
        ftime = {16'h1234, 16'h5678, 16'h9abc};
        fails = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd(bpf_pkg::OFF_CTRL, 32'h0);
        rd(bpf_pkg::OFF_BDIV, 32'h0);
        rd(bpf_pkg::OFF_LBL, 32'h7650);
        rd(8'h20, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        apb(1'b1, bpf_pkg::OFF_FLEN, 32'h5);
        rd(bpf_pkg::OFF_FLEN, 32'h80);
        apb(1'b1, bpf_pkg::OFF_BDIV, 32'h1);
        // parity, time, crc; twenty words overrun the sixteen places
        f0 = rx.frames;
        apb(1'b1, bpf_pkg::OFF_CTRL, 32'h0f);
        for (int i = 0; i < 20; i++) begin
            push(4'hd, i);
        end
        @(posedge clk);
        in_valid <= 1'b0;
        chk("in ready", {31'h0, in_ready}, 32'h0);
        ew[0] = 24'hfaf320;
        ew[1] = fmtw(1'b1, 4'h0, 4'h7, ftime.hi);
        ew[2] = fmtw(1'b1, 4'h0, 4'h7, ftime.lo);
        ew[3] = fmtw(1'b1, 4'h0, 4'h7, ftime.us);
        for (int i = 0; i < 16; i++) begin
            ew[4 + i] = fmtw(1'b1, 4'hd, i == 2 ? 4'hc : i == 3 ? 4'h8
                : 4'h9, idat(i));
        end
        ew[20] = fmtw(1'b1, 4'hd, 4'h0, 16'h0004);
        fill(21, 127, 1'b1);
        seal(128, 1'b1);
        frame(128);
        rd(bpf_pkg::OFF_DROP, 32'h4);
        // no parity, time or crc: four bit label, data after sync
        apb(1'b1, bpf_pkg::OFF_CTRL, 32'h0);
        repeat (60) @(posedge clk);
        apb(1'b1, bpf_pkg::OFF_FLEN, 32'h82);
        f0 = rx.frames;
        apb(1'b1, bpf_pkg::OFF_CTRL, 32'h01);
        for (int i = 0; i < 3; i++) begin
            push(4'hb, i + 4);
            ew[1 + i] = fmtw(1'b0, 4'hb, 4'h9, idat(i + 4));
        end
        @(posedge clk);
        in_valid <= 1'b0;
        fill(4, 130, 1'b0);
        frame(130);
        // fill suppressed: line waits for data
        apb(1'b1, bpf_pkg::OFF_CTRL, 32'h0);
        repeat (60) @(posedge clk);
        apb(1'b1, bpf_pkg::OFF_CTRL, 32'h11);
        push(4'hb, 4);
        push(4'hb, 5);
        @(posedge clk);
        in_valid <= 1'b0;
        repeat (500) @(negedge clk);
        chk("slots", rx.slot, 32'h3);
        chk("idle", {31'h0, rx.gap > 300}, 32'h1);
        chk("held word", {8'h0, rx.mem[2]}, {8'h0, ew[2]});
        print_verdict();
    end
endmodule
